//--- tbfi_pkg.sv
// constants for the terminal bus fault indicator block
// assumes a 100 MHz hclk and a single ahb-lite master
package tbfi_pkg;
	// clock rate
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
	localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
	// blink half periods, in ms
	localparam int unsigned FAST_HALF_MS = 50;
	localparam int unsigned SLOW_HALF_MS = 250;
	localparam int unsigned FAST_HALF_CYC = FAST_HALF_MS * CLK_PER_MS;
	localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_MS * CLK_PER_MS;
	// terminal bus update period, in us (inside 1..5 ms)
	localparam int unsigned BUS_CYCLE_US = 2000;
	localparam int unsigned BUS_CYCLE_CYC = BUS_CYCLE_US * CLK_PER_US;
	// acyclic restart window after a device reset request, in us
	localparam int unsigned RESTART_US = 10;
	localparam logic [9:0] RESTART_CYC = 10'(RESTART_US * CLK_PER_US);
	// half periods per report phase
	localparam logic [5:0] BURST_HALVES = 6'h0A;
	localparam logic [5:0] PAUSE_HALVES = 6'h04;
	localparam logic [5:0] GAP_HALVES = 6'h08;
	// register byte offsets
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_PASSIVE = 8'h08;
	localparam logic [7:0] OFS_REPORT = 8'h0C;
	// ctrl and report fields
	localparam int unsigned CTRL_RESET_BIT = 0;
	localparam int unsigned REP_ARG_LSB = 0;
	localparam int unsigned REP_CODE_LSB = 8;
	localparam int unsigned REP_ACTIVE_BIT = 16;
	// status word bits
	localparam int unsigned STS_BUS_FAULT = 0;
	localparam int unsigned STS_CFG_CHG = 1;
	localparam int unsigned STS_LEN_MISM = 2;
	localparam int unsigned STS_NO_INPUTS = 8;
	localparam int unsigned STS_IN_BUSY = 9;
	localparam int unsigned STS_OUT_BUSY = 10;
	localparam int unsigned STS_WATCHDOG = 11;
	localparam int unsigned STS_ACYCLIC = 15;
	// fault kinds reported by the bus engine
	localparam logic [2:0] KIND_CMD = 3'h0;
	localparam logic [2:0] KIND_BREAK = 3'h1;
	localparam logic [2:0] KIND_REGACC = 3'h2;
	localparam logic [2:0] KIND_INIT = 3'h3;
	localparam logic [2:0] KIND_INT_A = 3'h4;
	localparam logic [2:0] KIND_INT_B = 3'h5;
	localparam logic [2:0] KIND_LEN = 3'h6;
	// blink codes and fixed arguments
	localparam logic [2:0] CODE_CMD = 3'h3;
	localparam logic [2:0] CODE_BREAK = 3'h4;
	localparam logic [2:0] CODE_REGACC = 3'h5;
	localparam logic [2:0] CODE_INTERNAL = 3'h6;
	localparam logic [2:0] CODE_LEN = 3'h7;
	localparam logic [5:0] ARG_INT_A = 6'h01;
	localparam logic [5:0] ARG_INT_B = 6'h08;
	// report sequencer states
	typedef enum logic [2:0] {
		SQ_IDLE, SQ_START, SQ_CODE, SQ_PAUSE, SQ_ARG, SQ_GAP
	} tbfi_seq_t;
endpackage

//--- tbfi_rate_gen.sv
// three free dividers giving one-cycle enables: fast, slow, bus cycle
// assumes hclk only; clear restarts the two blink dividers
`timescale 1ns/1ps
`default_nettype none
module tbfi_rate_gen #(
	parameter int unsigned FAST_CYC = tbfi_pkg::FAST_HALF_CYC,
	parameter int unsigned SLOW_CYC = tbfi_pkg::SLOW_HALF_CYC,
	parameter int unsigned BUSCYC_CYC = tbfi_pkg::BUS_CYCLE_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clear,
	output logic [2:0] tick
);
	// terminal counts, one per divider
	localparam logic [31:0] LIM [3] = '{32'(FAST_CYC - 1),
		32'(SLOW_CYC - 1), 32'(BUSCYC_CYC - 1)};
	// bus cycle divider never stops, blink dividers restart per report
	logic [2:0] clr;
	assign clr = {1'b0, clear, clear};

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_div
			logic [31:0] cnt_q; // cycles since last tick
			logic tick_q; // own flop, so each bit has one driver
			// count up, wrap at the limit and flag that cycle
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					cnt_q <= 32'h0000_0000;
					tick_q <= 1'b0;
				end else if (clr[g]) begin
					cnt_q <= 32'h0000_0000;
					tick_q <= 1'b0;
				end else if (cnt_q == LIM[g]) begin
					cnt_q <= 32'h0000_0000;
					tick_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 32'h0000_0001;
					tick_q <= 1'b0;
				end
			end
			assign tick[g] = tick_q;
		end
	endgenerate
endmodule
`default_nettype wire

//--- tbfi_top.sv
// terminal bus fault indicator: run/error leds, blink reports, status
// assumes an ahb-lite master and a bus engine that flags fault causes
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tbfi_top #(
	parameter int unsigned FAST_HALF_CYC = tbfi_pkg::FAST_HALF_CYC,
	parameter int unsigned SLOW_HALF_CYC = tbfi_pkg::SLOW_HALF_CYC,
	parameter int unsigned BUS_CYCLE_CYC = tbfi_pkg::BUS_CYCLE_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic fault_active,
	input wire logic [2:0] fault_kind,
	input wire logic [5:0] fault_slot,
	input wire logic fieldbus_ok,
	input wire logic cfg_changed,
	input wire logic no_valid_inputs,
	input wire logic in_update_busy,
	input wire logic out_update_busy,
	input wire logic watchdog_hit,
	input wire logic task_tick,
	input wire logic cycle_done,
	output logic run_led,
	output logic err_led,
	output logic bus_restart,
	output logic bus_cycle_start
);
	// ---- dividers ----
	logic [2:0] tick; // fast, slow, bus cycle enables
	logic fast_tick;
	logic slow_tick;
	tbfi_pkg::tbfi_seq_t state_q; // report sequencer state

	tbfi_rate_gen #(
		.FAST_CYC(FAST_HALF_CYC),
		.SLOW_CYC(SLOW_HALF_CYC),
		.BUSCYC_CYC(BUS_CYCLE_CYC)
	) u_rate (
		.hclk(hclk),
		.hresetn(hresetn),
		.clear(state_q == tbfi_pkg::SQ_IDLE),
		.tick(tick)
	);
	assign fast_tick = tick[0];
	assign slow_tick = tick[1];

	// ---- ahb-lite slave ----
	logic addr_phase; // transfer accepted this edge
	logic wr_pend_q; // write waiting for its data phase
	logic [7:0] wr_ofs_q; // offset of pending write
	logic wr_hit_q; // pending write targets the register window
	logic hready_q;
	logic hresp_q;
	logic [31:0] hrdata_q;
	logic [31:0] passive_q; // one bit per slot, set when passive
	logic rst_req; // device reset request written this cycle
	logic [31:0] rd_mux;
	logic [15:0] status_q; // bus diag status word
	logic fault_q; // a fault report is held
	logic sticky_q; // held fault survives everything but hresetn
	logic [2:0] code_q; // blink code of held fault
	logic [5:0] arg_q; // blink argument of held fault
	logic [9:0] busy_cnt_q; // acyclic restart window
	logic bus_restart_q;

	assign addr_phase = hsel && htrans[1] && hready;

	// register window is the low 16 bytes; all else reads zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (haddr[31:4] == 28'h000_0000) begin
			unique case (haddr[7:0])
				tbfi_pkg::OFS_STATUS: rd_mux = {16'h0000, status_q};
				tbfi_pkg::OFS_CTRL: rd_mux[tbfi_pkg::CTRL_RESET_BIT] =
					busy_cnt_q != 10'h000;
				tbfi_pkg::OFS_PASSIVE: rd_mux = passive_q;
				tbfi_pkg::OFS_REPORT: begin
					rd_mux[tbfi_pkg::REP_ARG_LSB +: 6] = arg_q;
					rd_mux[tbfi_pkg::REP_CODE_LSB +: 3] = code_q;
					rd_mux[tbfi_pkg::REP_ACTIVE_BIT] = fault_q;
				end
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// address phase capture; read data is ready for the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_ofs_q <= 8'h00;
			wr_hit_q <= 1'b0;
			hrdata_q <= 32'h0000_0000;
		end else begin
			wr_pend_q <= addr_phase && hwrite;
			if (addr_phase) begin
				wr_ofs_q <= haddr[7:0];
				wr_hit_q <= haddr[31:4] == 28'h000_0000;
			end
			// zero between reads so stale data never lingers
			hrdata_q <= (addr_phase && !hwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// zero wait states and always okay, so these never move
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hready_q <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			hready_q <= 1'b1;
			hresp_q <= 1'b0;
		end
	end

	// device reset request: write one to the ctrl bit
	assign rst_req = wr_pend_q && wr_hit_q &&
		wr_ofs_q == tbfi_pkg::OFS_CTRL &&
		hwdata[tbfi_pkg::CTRL_RESET_BIT];

	// passive slot mask, written by software
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			passive_q <= 32'h0000_0000;
		end else if (wr_pend_q && wr_hit_q &&
				wr_ofs_q == tbfi_pkg::OFS_PASSIVE) begin
			passive_q <= hwdata;
		end
	end

	// ---- position of last active terminal before fault ----
	logic [31:0] act_before; // active slots below fault_slot
	logic [5:0] pos_cnt;
	genvar s;
	generate
		for (s = 0; s < 32; s++) begin : g_slot
			assign act_before[s] = (6'(s) < fault_slot) && !passive_q[s];
		end
	endgenerate

	// population count of the active slots
	always_comb begin
		pos_cnt = 6'h00;
		for (int i = 0; i < 32; i++) begin
			pos_cnt = pos_cnt + {5'h00, act_before[i]};
		end
	end

	// ---- fault capture ----
	logic accept; // take a new fault report
	logic [2:0] new_code;
	logic [5:0] new_arg;
	logic new_sticky;
	// a reset request blocks capture, so a restart never re-latches at once
	assign accept = fault_active && !fault_q && !rst_req &&
		busy_cnt_q == 10'h000;

	// map the fault kind onto code, argument and stickiness
	always_comb begin
		new_code = tbfi_pkg::CODE_CMD;
		new_arg = 6'h00;
		new_sticky = 1'b0;
		unique case (fault_kind)
			tbfi_pkg::KIND_CMD: new_code = tbfi_pkg::CODE_CMD;
			tbfi_pkg::KIND_BREAK: begin
				new_code = tbfi_pkg::CODE_BREAK;
				new_arg = pos_cnt;
			end
			tbfi_pkg::KIND_REGACC: begin
				new_code = tbfi_pkg::CODE_REGACC;
				new_arg = pos_cnt;
			end
			tbfi_pkg::KIND_INIT: begin
				new_code = tbfi_pkg::CODE_INTERNAL;
				new_sticky = 1'b1;
			end
			tbfi_pkg::KIND_INT_A: begin
				new_code = tbfi_pkg::CODE_INTERNAL;
				new_arg = tbfi_pkg::ARG_INT_A;
				new_sticky = 1'b1;
			end
			tbfi_pkg::KIND_INT_B: begin
				new_code = tbfi_pkg::CODE_INTERNAL;
				new_arg = tbfi_pkg::ARG_INT_B;
				new_sticky = 1'b1;
			end
			tbfi_pkg::KIND_LEN: new_code = tbfi_pkg::CODE_LEN;
			default: new_code = tbfi_pkg::CODE_CMD; // unused kind
		endcase
	end

	// hold the first fault; internal ones only leave on hresetn
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fault_q <= 1'b0;
			sticky_q <= 1'b0;
			code_q <= 3'h0;
			arg_q <= 6'h00;
		end else begin
			// cause gone or reset request, unless sticky
			if (!sticky_q && (rst_req || !fault_active)) begin
				fault_q <= 1'b0;
			end
			// a new cause wins over a clear in the same cycle
			if (accept) begin
				fault_q <= 1'b1;
				sticky_q <= new_sticky;
				code_q <= new_code;
				arg_q <= new_arg;
			end
		end
	end

	// restart pulse and acyclic window; events ignored meanwhile
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_restart_q <= 1'b0;
			busy_cnt_q <= 10'h000;
		end else begin
			bus_restart_q <= rst_req && !sticky_q;
			if (rst_req && !sticky_q) begin
				busy_cnt_q <= tbfi_pkg::RESTART_CYC;
			end else if (busy_cnt_q != 10'h000) begin
				busy_cnt_q <= busy_cnt_q - 10'h001;
			end
		end
	end

	// ---- synchronism with the host task ----
	logic done_seen_q; // a bus cycle finished since last task tick
	logic lag_q; // last task period saw no finished cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_seen_q <= 1'b0;
			lag_q <= 1'b0;
		end else if (task_tick) begin
			done_seen_q <= cycle_done;
			lag_q <= !(done_seen_q || cycle_done);
		end else if (cycle_done) begin
			done_seen_q <= 1'b1;
		end
	end

	// ---- status word ----
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_q <= 16'h0000;
		end else begin
			status_q <= 16'h0000;
			status_q[tbfi_pkg::STS_BUS_FAULT] <= fault_q;
			status_q[tbfi_pkg::STS_CFG_CHG] <= cfg_changed;
			status_q[tbfi_pkg::STS_LEN_MISM] <= fault_q &&
				code_q == tbfi_pkg::CODE_LEN;
			status_q[tbfi_pkg::STS_NO_INPUTS] <= no_valid_inputs;
			status_q[tbfi_pkg::STS_IN_BUSY] <= in_update_busy || lag_q;
			status_q[tbfi_pkg::STS_OUT_BUSY] <= out_update_busy || lag_q;
			status_q[tbfi_pkg::STS_WATCHDOG] <= watchdog_hit;
			status_q[tbfi_pkg::STS_ACYCLIC] <= bus_restart_q ||
				busy_cnt_q != 10'h000;
		end
	end

	// ---- leds and bus cycle pacing ----
	logic run_led_q;
	logic err_led_q;
	logic cyc_start_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_led_q <= 1'b0;
			cyc_start_q <= 1'b0;
		end else begin
			run_led_q <= !fault_q && fieldbus_ok && !lag_q;
			// no update cycles while the restart window runs
			cyc_start_q <= tick[2] && busy_cnt_q == 10'h000;
		end
	end

	// ---- blink report sequencer ----
	logic [5:0] cnt_q; // half periods or pulses in this phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= tbfi_pkg::SQ_IDLE;
			cnt_q <= 6'h00;
			err_led_q <= 1'b0;
		end else if (!fault_q) begin
			// no fault: led dark, blink dividers held
			state_q <= tbfi_pkg::SQ_IDLE;
			cnt_q <= 6'h00;
			err_led_q <= 1'b0;
		end else begin
			unique case (state_q)
				tbfi_pkg::SQ_IDLE: begin
					state_q <= tbfi_pkg::SQ_START;
					cnt_q <= 6'h00;
					err_led_q <= 1'b0;
				end
				tbfi_pkg::SQ_START: if (fast_tick) begin
					if (cnt_q == tbfi_pkg::BURST_HALVES - 6'h01) begin
						state_q <= tbfi_pkg::SQ_CODE;
						cnt_q <= 6'h00;
						err_led_q <= 1'b0;
					end else begin
						err_led_q <= !err_led_q;
						cnt_q <= cnt_q + 6'h01;
					end
				end
				tbfi_pkg::SQ_CODE: if (slow_tick) begin
					err_led_q <= !err_led_q;
					if (err_led_q) begin
						// a pulse ends here; count it
						if (cnt_q + 6'h01 == {3'h0, code_q}) begin
							state_q <= tbfi_pkg::SQ_PAUSE;
							cnt_q <= 6'h00;
						end else begin
							cnt_q <= cnt_q + 6'h01;
						end
					end
				end
				tbfi_pkg::SQ_PAUSE: if (slow_tick) begin
					if (cnt_q == tbfi_pkg::PAUSE_HALVES - 6'h01) begin
						// argument zero shows no pulses at all
						state_q <= (arg_q == 6'h00) ? tbfi_pkg::SQ_GAP :
							tbfi_pkg::SQ_ARG;
						cnt_q <= 6'h00;
					end else begin
						cnt_q <= cnt_q + 6'h01;
					end
				end
				tbfi_pkg::SQ_ARG: if (slow_tick) begin
					err_led_q <= !err_led_q;
					if (err_led_q) begin
						if (cnt_q + 6'h01 == arg_q) begin
							state_q <= tbfi_pkg::SQ_GAP;
							cnt_q <= 6'h00;
						end else begin
							cnt_q <= cnt_q + 6'h01;
						end
					end
				end
				tbfi_pkg::SQ_GAP: if (slow_tick) begin
					if (cnt_q == tbfi_pkg::GAP_HALVES - 6'h01) begin
						state_q <= tbfi_pkg::SQ_START;
						cnt_q <= 6'h00;
					end else begin
						cnt_q <= cnt_q + 6'h01;
					end
				end
			endcase
		end
	end

	assign hreadyout = hready_q;
	assign hresp = hresp_q;
	assign hrdata = hrdata_q;
	assign run_led = run_led_q;
	assign err_led = err_led_q;
	assign bus_restart = bus_restart_q;
	assign bus_cycle_start = cyc_start_q;

	// ---- checks ----
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_burst_done;
		(state_q == tbfi_pkg::SQ_START) ##1 (state_q == tbfi_pkg::SQ_CODE);
	endsequence
	sequence s_code_done;
		(state_q == tbfi_pkg::SQ_CODE) ##1 (state_q == tbfi_pkg::SQ_PAUSE);
	endsequence

	chk_dark_no_fault: assert property (
		!fault_q |=> !err_led_q)
		else $error("error led lit without a fault");
	chk_run_led_off: assert property (
		(fault_q || !fieldbus_ok) |=> !run_led_q)
		else $error("run led lit during a fault");
	chk_fast_toggle: assert property (
		(fault_q && state_q == tbfi_pkg::SQ_START && fast_tick)
		|=> $changed(err_led_q))
		else $error("start burst missed a fast toggle");
	chk_burst_then_code: assert property (
		s_burst_done |-> !err_led_q && cnt_q == 6'h00)
		else $error("code phase began with led lit");
	chk_pause_dark: assert property (
		s_code_done |-> !err_led_q [*2])
		else $error("pause phase not dark");
	chk_arg_position: assert property (
		(accept && fault_kind == tbfi_pkg::KIND_BREAK)
		|=> arg_q == $past(pos_cnt) && arg_q <= $past(fault_slot))
		else $error("break argument not the terminal position");
	chk_cmd_report: assert property (
		(accept && fault_kind == tbfi_pkg::KIND_CMD)
		|=> code_q == tbfi_pkg::CODE_CMD && arg_q == 6'h00)
		else $error("command error not reported as 3/0");
	chk_len_report: assert property (
		(accept && fault_kind == tbfi_pkg::KIND_LEN)
		|=> code_q == tbfi_pkg::CODE_LEN ##1 status_q[tbfi_pkg::STS_LEN_MISM])
		else $error("length mismatch not reported");
	chk_sticky_hold: assert property (
		(fault_q && sticky_q) |=> fault_q)
		else $error("sticky fault left before power cycle");
	chk_zero_status: assert property (
		(status_q == 16'h0000) |-> !$past(fault_q) && !$past(lag_q))
		else $error("status zero while faulted");
	chk_reset_clear: assert property (
		(rst_req && !sticky_q) |=> !fault_q && bus_restart_q
		##1 status_q[tbfi_pkg::STS_ACYCLIC])
		else $error("reset request did not clear and restart");
endmodule
`default_nettype wire

//--- tbfi_chain_model.sv
// model of the terminal chain behind the fault indicator block
// assumes hclk only; the bench decides when a fault is shown
`timescale 1ns/1ps
`default_nettype none
module tbfi_chain_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic inj,
	input wire logic [2:0] inj_kind,
	input wire logic [5:0] inj_slot,
	input wire logic slow,
	input wire logic bus_cycle_start,
	output logic fault_active,
	output logic [2:0] fault_kind,
	output logic [5:0] fault_slot,
	output logic cycle_done
);
	logic [1:0] pend_q; // cycle in flight, three cycles of latency

	// fault cause; kind and slot go stale when no fault is shown
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fault_active <= 1'b0;
			fault_kind <= 3'h0;
			fault_slot <= 6'h00;
		end else begin
			fault_active <= inj;
			if (inj) begin
				fault_kind <= inj_kind;
				fault_slot <= inj_slot;
			end else begin
				// invert so a stale sample is never mistaken as valid
				fault_kind <= ~fault_kind;
				fault_slot <= ~fault_slot;
			end
		end
	end

	// prompt chain finishes each cycle; a slow one never does
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_q <= 2'h0;
			cycle_done <= 1'b0;
		end else begin
			pend_q <= {pend_q[0], bus_cycle_start & ~slow};
			cycle_done <= pend_q[1];
		end
	end
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the fault indicator block
// assumes the chain model beside it and short blink dividers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int FAST = 4; // shortened dividers
	localparam int SLOW = 8;
	localparam int BUSC = 16;
	localparam logic [31:0] A_STS = 32'(tbfi_pkg::OFS_STATUS);
	localparam logic [31:0] A_CTL = 32'(tbfi_pkg::OFS_CTRL);
	localparam logic [31:0] A_PAS = 32'(tbfi_pkg::OFS_PASSIVE);
	localparam logic [31:0] A_REP = 32'(tbfi_pkg::OFS_REPORT);
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize, fault_kind, inj_kind;
	logic [5:0] fault_slot, inj_slot;
	logic fault_active, fieldbus_ok, task_tick, cycle_done, inj, slow;
	logic run_led, err_led, bus_restart, bus_cycle_start;
	logic [4:0] lvl; // cfg, no inputs, in busy, out busy, watchdog
	int num_errors, n_tests, restart_cnt;

	tbfi_top #(.FAST_HALF_CYC(FAST), .SLOW_HALF_CYC(SLOW),
		.BUS_CYCLE_CYC(BUSC)) tbfi_top_inst (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .fault_active(fault_active),
		.fault_kind(fault_kind), .fault_slot(fault_slot),
		.fieldbus_ok(fieldbus_ok), .cfg_changed(lvl[0]),
		.no_valid_inputs(lvl[1]), .in_update_busy(lvl[2]),
		.out_update_busy(lvl[3]), .watchdog_hit(lvl[4]),
		.task_tick(task_tick), .cycle_done(cycle_done),
		.run_led(run_led), .err_led(err_led), .bus_restart(bus_restart),
		.bus_cycle_start(bus_cycle_start));

	tbfi_chain_model tbfi_chain_model_inst (.hclk(hclk),
		.hresetn(hresetn), .inj(inj), .inj_kind(inj_kind),
		.inj_slot(inj_slot), .slow(slow),
		.bus_cycle_start(bus_cycle_start), .fault_active(fault_active),
		.fault_kind(fault_kind), .fault_slot(fault_slot),
		.cycle_done(cycle_done));

	// 100 MHz clock
	always #5 hclk = ~hclk;

	// counts restart pulses seen
	always @(posedge hclk) if (bus_restart === 1'b1) restart_cnt++;

	task automatic end_sim;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check32(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask

	task automatic check_str(input string nm, input string e, input string g);
		n_tests++;
		if (g != e) begin
			$display("Error %s expected %s seen %s", nm, e, g);
			num_errors++;
		end
	endtask

	// one single ahb-lite transfer; waits on hready with a bound
	task automatic ahb(input logic wr, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		int k;
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		k = 0;
		do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
		htrans <= 2'h0;
		hsel <= 1'b0;
		if (wr) hwdata <= wd;
		do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 99);
		rd = hrdata;
		check32("hresp", 32'h0, {31'h0, hresp});
		if (k >= 99) begin
			num_errors++;
			end_sim();
		end
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		ahb(1'b0, a, 32'h0, d);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask

	// one host task period, far below the host period limit
	task automatic tick();
		task_tick <= 1'b1;
		@(posedge hclk);
		task_tick <= 1'b0;
		repeat (40) @(posedge hclk);
	endtask

	task automatic sc_idle();
		logic [31:0] d;
		int k;
		repeat (40) @(posedge hclk);
		rd(A_STS, d);
		check32("status", 32'h0, d);
		check32("run_led", 32'h1, {31'h0, run_led});
		check32("err_led", 32'h0, {31'h0, err_led});
		rd(32'h10, d);
		check32("unmapped", 32'h0, d);
		k = 0;
		do begin @(posedge hclk); k++; end while (bus_cycle_start !== 1'b1 && k < 99);
		if (k >= 99) begin
			num_errors++;
			end_sim();
		end
		k = 0;
		do begin @(posedge hclk); k++; end while (bus_cycle_start !== 1'b1 && k < 99);
		if (k >= 99) begin
			num_errors++;
			end_sim();
		end
		check32("cycle_period", 32'(BUSC), 32'(k));
	endtask

	task automatic sc_levels();
		int bp[5] = '{1, 8, 9, 10, 11};
		logic [31:0] d;
		for (int i = 0; i < 5; i++) begin
			lvl <= 5'(1 << i);
			repeat (3) @(posedge hclk);
			rd(A_STS, d);
			check32("status_level", 32'h1 << bp[i], d);
		end
		lvl <= 5'h00;
		fieldbus_ok <= 1'b0;
		repeat (3) @(posedge hclk);
		check32("run_led_fb", 32'h0, {31'h0, run_led});
		fieldbus_ok <= 1'b1;
		// slow chain: cycles overrun the task period
		slow <= 1'b1;
		// a cycle already in flight may still finish in the first period
		tick();
		tick();
		tick();
		rd(A_STS, d);
		check32("status_lag", 32'h600, d & 32'h600);
		check32("run_led_lag", 32'h0, {31'h0, run_led});
		slow <= 1'b0;
		tick();
		tick();
		rd(A_STS, d);
		check32("status_sync", 32'h0, d);
	endtask

	task automatic sc_codes();
		logic [2:0] kd[7] = '{0, 1, 2, 6, 3, 4, 5};
		logic [5:0] sl[7] = '{9, 5, 2, 9, 9, 9, 9};
		logic [31:0] ex[7] = '{32'h10300, 32'h10403, 32'h10501,
			32'h10700, 32'h10600, 32'h10601, 32'h10608};
		logic [31:0] d;
		for (int i = 0; i < 7; i++) begin
			// slots 1 and 3 passive
			wr(A_PAS, 32'h0A);
			inj_kind <= kd[i];
			inj_slot <= sl[i];
			inj <= 1'b1;
			repeat (4) @(posedge hclk);
			rd(A_REP, d);
			check32("report", ex[i], d);
			rd(A_STS, d);
			check32("status_fault", 32'h1, d & 32'h1);
			check32("run_led_fault", 32'h0, {31'h0, run_led});
			inj <= 1'b0;
			repeat (6) @(posedge hclk);
			rd(A_REP, d);
			if (i < 4) begin
				check32("report_clear", 32'h0, d & 32'h10000);
			end else begin
				check32("report_sticky", ex[i], d);
				wr(A_CTL, 32'h1);
				repeat (5) @(posedge hclk);
				rd(A_REP, d);
				check32("report_sticky_req", ex[i], d);
				hresetn <= 1'b0;
				repeat (10) @(posedge hclk);
				hresetn <= 1'b1;
			end
		end
	endtask

	// led trace: F fast flash, S slow flash, bar for a long dark
	task automatic sc_blink();
		string s;
		int hi, lo;
		logic p;
		wr(A_PAS, 32'h0A);
		s = "";
		hi = 0;
		lo = 0;
		p = 1'b0;
		inj_kind <= 3'h1;
		inj_slot <= 6'h03;
		inj <= 1'b1;
		repeat (400) begin
			@(posedge hclk);
			if (err_led === 1'b1) begin
				if (!p && lo > 20 && s.len() > 0) s = {s, "|"};
				hi++;
				lo = 0;
				p = 1'b1;
			end else begin
				if (p) s = {s, (hi < 6) ? "F" : "S"};
				lo++;
				hi = 0;
				p = 1'b0;
			end
		end
		inj <= 1'b0;
		check_str("blink", "FFFFFSSSS|SS|F", s.substr(0, 13));
		repeat (10) @(posedge hclk);
	endtask

	task automatic sc_restart();
		logic [31:0] d;
		int c0;
		inj_kind <= 3'h1;
		inj_slot <= 6'h00;
		inj <= 1'b1;
		repeat (4) @(posedge hclk);
		c0 = restart_cnt;
		wr(A_CTL, 32'h1);
		repeat (4) @(posedge hclk);
		check32("restart_pulses", 32'h1, 32'(restart_cnt - c0));
		rd(A_STS, d);
		check32("status_acyclic", 32'h8000, d & 32'h8000);
		rd(A_REP, d);
		check32("report_reset", 32'h0, d & 32'h10000);
		rd(A_CTL, d);
		check32("ctrl_busy", 32'h1, d & 32'h1);
		repeat (1100) @(posedge hclk);
		rd(A_REP, d);
		check32("report_again", 32'h10400, d);
		rd(A_STS, d);
		check32("acyclic_done", 32'h0, d & 32'h8000);
		inj <= 1'b0;
	endtask

	// main sequence
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		fieldbus_ok = 1'b1;
		task_tick = 1'b0;
		inj = 1'b0;
		inj_kind = 3'h0;
		inj_slot = 6'h00;
		slow = 1'b0;
		lvl = 5'h00;
		num_errors = 0;
		n_tests = 0;
		restart_cnt = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		sc_idle();
		sc_levels();
		sc_codes();
		sc_blink();
		sc_restart();
		end_sim();
	end

	// hang guard
	initial begin
		repeat (100000) @(posedge hclk);
		num_errors++;
		end_sim();
	end
endmodule
`default_nettype wire
